// ==== rtl/tcc_pkg.sv ====
package tcc_pkg;
   // register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // register indices on the plain port
   localparam logic [2:0] ADDR_COUNT  = 3'h0;
   localparam logic [2:0] ADDR_CCA    = 3'h1;
   localparam logic [2:0] ADDR_CCB    = 3'h2;
   localparam logic [2:0] ADDR_MODE   = 3'h3;
   localparam logic [2:0] ADDR_CCCTL  = 3'h4;
   localparam logic [2:0] ADDR_OUTCTL = 3'h5;
   localparam logic [2:0] ADDR_PRESC  = 3'h6;

   // timer_mode_control fields
   localparam int MODE_OVF_BIT    = 0;
   localparam int MODE_TOGGLE_BIT = 1;
   localparam int MODE_RUN_LO_BIT = 2;
   localparam int MODE_RUN_HI_BIT = 3;

   // cc_control fields
   localparam int CC_A_MODE_BIT = 0;
   localparam int CC_A_TRIG_BIT = 1;
   localparam int CC_B_MODE_BIT = 2;

   // output_control fields
   localparam int OUT_ENABLE_BIT  = 0;
   localparam int OUT_INV_B_BIT   = 4;
   localparam int OUT_OS_EN_BIT   = 5;
   localparam int OUT_OS_TRIG_BIT = 6;

   // prescaler_mode fields
   localparam int PRESC_CLK_LSB    = 0;
   localparam int PRESC_EDGE_A_LSB = 4;
   localparam int PRESC_EDGE_B_LSB = 6;

   // run-mode encodings (hi, lo)
   localparam logic [1:0] RUN_STOP      = 2'h0;
   localparam logic [1:0] RUN_FREE      = 2'h1;
   localparam logic [1:0] RUN_CLR_EDGE  = 2'h2;
   localparam logic [1:0] RUN_CLR_MATCH = 2'h3;

   // valid-edge encodings
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // count clock select encodings
   localparam logic [1:0] CLK_DIV1   = 2'h0;
   localparam logic [1:0] CLK_DIV4   = 2'h1;
   localparam logic [1:0] CLK_DIV16  = 2'h2;
   localparam logic [1:0] CLK_DIV256 = 2'h3;

   // reset values and limits
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] CC_RST    = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [7:0]  CTRL_RST  = 8'h00;
endpackage

// ==== rtl/tcc_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_sync
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // pin side
   input  wire logic pinIn,
   // edge pulses
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // meta_q feeds sync_q only
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// ==== rtl/tcc_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // control
   input  wire logic       run,
   input  wire logic [1:0] sel,
   // count clock enable
   output logic            tick
);
   import tcc_pkg::*;

   logic [7:0] div_q;

   // restarts on stop so the first tick phase is predictable
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         div_q <= 8'h00;
      else if (!run)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   always_comb
   begin
      case (sel)
         CLK_DIV1:   tick = run;
         CLK_DIV4:   tick = run && (div_q[1:0] == 2'h3);
         CLK_DIV16:  tick = run && (div_q[3:0] == 4'hf);
         CLK_DIV256: tick = run && (div_q == 8'hff);
         default:    tick = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== rtl/tcc_timer16.sv ====
// Overview of operation
// R1 - timer count is a 16-bit read-only register
// R2 - count increments by one on each count clock tick while running
// R3 - reading the count holds off that tick and returns the present value
// R4 - count is zero after reset and while both run-mode bits are zero
// R5 - edge clear-and-start mode clears count on each valid edge of input a
// R6 - match clear-and-start mode clears count when it equals register a
// R7 - one-shot mode: software trigger bit clears the count
// R8 - cc control bit 0: register a compare (0) or capture (1)
// R9 - cc control bit 2: register b compare (0) or capture (1)
// R10 - register a compare mode: equality with count raises match interrupt a
// R11 - register b compare mode: equality with count raises match interrupt b
// R12 - a captures input a opposite edge: 00 rising, 01 falling, 11 none
// R13 - a captures input b edge: 00 falling, 01 rising, 11 both
// R14 - software never programs edge code 10 in either field
// R15 - register b captures count on valid edge of input a
// R16 - software loads nonzero compare values in match clear mode
// R17 - compare value zero matches on step 0000 to 0001 after wrap
// R18 - compare value below count matches only after wrapping through zero
// R19 - capture register read during a capture returns old data, capture intact
// R20 - stop coinciding with capture: capture still takes the running count
// R21 - shared pin is either edge input b or timer output, never both
// R22 - reset clears both capture/compare registers
// R23 - timer runs whenever run-mode bits are nonzero, stops at zero
// R24 - external trigger pulses last over two count clock periods
// R25 - overflow flag sets on wrap from ffff when register a is ffff
// R26 - edge inputs are synchronised and edge-detected before use
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // register port
   input  wire logic [tcc_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [tcc_pkg::DATA_W-1:0] regWrData,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output logic      [tcc_pkg::DATA_W-1:0] regRdData,
   // external edge input
   input  wire logic                      edgeInputA,
   // shared port pin
   input  wire logic                      sharedPinIn,
   output logic                           sharedPinOut,
   output logic                           sharedPinOe_n,
   // events and status
   output logic                           matchIrqA,
   output logic                           matchIrqB,
   output logic                           overflowFlag
);
   import tcc_pkg::*;

   logic [15:0] count_q;
   logic [15:0] ccA_q;
   logic [15:0] ccB_q;
   logic [1:0]  runMode_q;
   logic        toggleEdge_q;
   logic        ovf_q;
   logic [2:0]  ccCtl_q;
   logic        outEn_q;
   logic        invB_q;
   logic        osEn_q;
   logic [7:0]  presc_q;
   logic        toFlop_q;
   logic [15:0] rdData_q;
   logic        matchA_q;
   logic        matchB_q;
   logic wrCcA;
   logic wrCcB;
   logic wrMode;
   logic wrCcCtl;
   logic wrOut;
   logic wrPresc;
   logic running;
   logic tick;
   logic readHold;
   logic countStep;
   logic riseA;
   logic fallA;
   logic riseB;
   logic fallB;
   logic [1:0] edgeSelA;
   logic [1:0] edgeSelB;
   logic validA;
   logic validB;
   logic revA;
   logic capA;
   logic capB;
   logic eqA;
   logic eqB;
   logic matchA;
   logic matchB;
   logic clrEdge;
   logic clrMatch;
   logic osTrig;
   logic anyClear;
   logic ovfSet;
   logic toggleEv;
   // register port decode
   assign wrCcA   = regWrite && (regAddr == ADDR_CCA);
   assign wrCcB   = regWrite && (regAddr == ADDR_CCB);
   assign wrMode  = regWrite && (regAddr == ADDR_MODE);
   assign wrCcCtl = regWrite && (regAddr == ADDR_CCCTL);
   assign wrOut   = regWrite && (regAddr == ADDR_OUTCTL);
   assign wrPresc = regWrite && (regAddr == ADDR_PRESC);

   assign running  = (runMode_q != RUN_STOP); // R23
   // the tick is dropped, not deferred, so a read in a tick cycle costs one count
   assign readHold = regRead && (regAddr == ADDR_COUNT) && running; // R3
   assign countStep = tick && !readHold; // R2 R3

   tcc_prescaler u_presc
   (
      .clk   (clk),
      .reset (reset),
      .run   (running),
      .sel   (presc_q[PRESC_CLK_LSB +: 2]),
      .tick  (tick)
   );

   tcc_edge_sync u_syncA
   (
      .clk   (clk),
      .reset (reset),
      .pinIn (edgeInputA),
      .rise  (riseA),
      .fall  (fallA)
   );

   tcc_edge_sync u_syncB
   (
      .clk   (clk),
      .reset (reset),
      .pinIn (sharedPinIn),
      .rise  (riseB),
      .fall  (fallB)
   );

   function automatic logic validEdge(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         EDGE_FALL: validEdge = f;
         EDGE_RISE: validEdge = r;
         EDGE_BOTH: validEdge = r | f;
         default:   validEdge = 1'b0;
      endcase
   endfunction

   assign edgeSelA = presc_q[PRESC_EDGE_A_LSB +: 2];
   assign edgeSelB = presc_q[PRESC_EDGE_B_LSB +: 2];
   assign validA   = validEdge(edgeSelA, riseA, fallA); // R26
   // pin driven as output: its input side is ignored
   assign validB   = validEdge(edgeSelB, riseB, fallB) && !outEn_q; // R21 R26

   // reverse phase of input a; both-edge setting captures nothing
   always_comb
   begin
      case (edgeSelA)
         EDGE_FALL: revA = riseA;
         EDGE_RISE: revA = fallA;
         default:   revA = 1'b0;
      endcase
   end

   assign capA = ccCtl_q[CC_A_MODE_BIT] && running &&
                 (ccCtl_q[CC_A_TRIG_BIT] ? revA : validB); // R8 R12 R13
   assign capB = ccCtl_q[CC_B_MODE_BIT] && running && validA; // R9 R15

   // matching on the step out of the value gives the zero case for free
   assign eqA    = (count_q == ccA_q);
   assign eqB    = (count_q == ccB_q);
   assign matchA = !ccCtl_q[CC_A_MODE_BIT] && countStep && eqA; // R10 R17 R18
   assign matchB = !ccCtl_q[CC_B_MODE_BIT] && countStep && eqB; // R11 R17 R18

   assign clrEdge  = (runMode_q == RUN_CLR_EDGE) && validA; // R5
   assign clrMatch = (runMode_q == RUN_CLR_MATCH) && countStep && eqA; // R6
   assign osTrig   = wrOut && regWrData[OUT_OS_TRIG_BIT] &&
                     regWrData[OUT_OS_EN_BIT] && running; // R7
   assign anyClear = clrEdge || clrMatch || osTrig;
   assign ovfSet   = countStep && (count_q == COUNT_MAX) &&
                     (ccA_q == COUNT_MAX); // R25

   // timer count
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         count_q <= COUNT_RST; // R4
      else if (!running)
         count_q <= COUNT_RST; // R4 R23
      else if (anyClear)
         count_q <= COUNT_RST; // R5 R6 R7
      else if (countStep)
         count_q <= count_q + 16'h0001; // R2 R18
   end

   // capture wins over a software write in the same cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ccA_q <= CC_RST; // R22
      else if (capA)
         ccA_q <= count_q; // R12 R13 R20
      else if (wrCcA)
         ccA_q <= regWrData;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ccB_q <= CC_RST; // R22
      else if (capB)
         ccB_q <= count_q; // R15 R20
      else if (wrCcB)
         ccB_q <= regWrData;
   end

   // mode control
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         runMode_q    <= CTRL_RST[1:0];
         toggleEdge_q <= CTRL_RST[0];
      end
      else if (wrMode)
      begin
         runMode_q    <= {regWrData[MODE_RUN_HI_BIT], regWrData[MODE_RUN_LO_BIT]}; // R23
         toggleEdge_q <= regWrData[MODE_TOGGLE_BIT];
      end
   end

   // overflow: hardware set wins over a software clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ovf_q <= CTRL_RST[0];
      else if (ovfSet)
         ovf_q <= 1'b1; // R25
      else if (wrMode)
         ovf_q <= regWrData[MODE_OVF_BIT];
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ccCtl_q <= CTRL_RST[2:0];
      else if (wrCcCtl)
         ccCtl_q <= regWrData[2:0]; // R8 R9
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         outEn_q <= CTRL_RST[0];
         invB_q  <= CTRL_RST[0];
         osEn_q  <= CTRL_RST[0];
      end
      else if (wrOut)
      begin
         outEn_q <= regWrData[OUT_ENABLE_BIT]; // R21
         invB_q  <= regWrData[OUT_INV_B_BIT];
         osEn_q  <= regWrData[OUT_OS_EN_BIT];
      end
   end

   // edge code 10 is left to software to avoid; it simply never fires
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         presc_q <= CTRL_RST;
      else if (wrPresc)
         presc_q <= regWrData[7:0]; // R14
   end

   // timer output flip-flop
   assign toggleEv = matchA || (invB_q && matchB) ||
                     (toggleEdge_q && running && validA);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         toFlop_q <= 1'b0;
      else if (toggleEv)
         toFlop_q <= ~toFlop_q;
   end

   // match events as registered one-cycle pulses
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         matchA_q <= 1'b0;
         matchB_q <= 1'b0;
      end
      else
      begin
         matchA_q <= matchA; // R10
         matchB_q <= matchB; // R11
      end
   end

   // read data; a coincident capture returns the pre-capture value
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdData_q <= 16'h0000;
      else if (regRead)
      begin
         case (regAddr)
            ADDR_COUNT:  rdData_q <= count_q; // R1 R3
            ADDR_CCA:    rdData_q <= ccA_q; // R19
            ADDR_CCB:    rdData_q <= ccB_q; // R19
            ADDR_MODE:   rdData_q <= {12'h000, runMode_q, toggleEdge_q, ovf_q};
            ADDR_CCCTL:  rdData_q <= {13'h0, ccCtl_q};
            ADDR_OUTCTL: rdData_q <= {10'h000, osEn_q, invB_q, 3'h0, outEn_q};
            ADDR_PRESC:  rdData_q <= {8'h00, presc_q};
            default:     rdData_q <= 16'h0000;
         endcase
      end
      else
         rdData_q <= 16'h0000;
   end

   assign regRdData     = rdData_q;
   assign sharedPinOut  = toFlop_q;
   assign sharedPinOe_n = ~outEn_q; // R21
   assign matchIrqA     = matchA_q;
   assign matchIrqB     = matchB_q;
   assign overflowFlag  = ovf_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_count_stop: assert property (!running |=> count_q == 16'h0000) // R4
      else $error("count not zero after stop");
   chk_count_step: assert property // R2
      (countStep && !anyClear |=> count_q == $past(count_q) + 16'h0001)
      else $error("count did not step by one");
   chk_read_hold: assert property // R3
      (readHold && !anyClear |=> count_q == $past(count_q))
      else $error("count moved during read");
   chk_read_count: assert property // R1
      (regRead && regAddr == ADDR_COUNT |=> regRdData == $past(count_q))
      else $error("count read returned wrong value");
   chk_edge_clear: assert property (clrEdge |=> count_q == 16'h0000) // R5
      else $error("edge clear missed");
   chk_match_clear: assert property (clrMatch |=> count_q == 16'h0000) // R6
      else $error("match clear missed");
   chk_oneshot_clear: assert property (osTrig |=> count_q == 16'h0000) // R7
      else $error("one-shot clear missed");
   chk_match_a_irq: assert property // R10
      (countStep && count_q == ccA_q && !ccCtl_q[CC_A_MODE_BIT] |=> matchIrqA)
      else $error("match a pulse missing");
   chk_match_b_irq: assert property // R11
      (countStep && count_q == ccB_q && !ccCtl_q[CC_B_MODE_BIT] |=> matchIrqB)
      else $error("match b pulse missing");
   chk_capture_a: assert property (capA |=> ccA_q == $past(count_q)) // R12
      else $error("capture a wrong value");
   chk_capture_b: assert property (capB |=> ccB_q == $past(count_q)) // R15
      else $error("capture b wrong value");
   chk_overflow_set: assert property (ovfSet |=> overflowFlag) // R25
      else $error("overflow flag not set");
   chk_pin_share: assert property // R21
      (!sharedPinOe_n && !ccCtl_q[CC_A_TRIG_BIT] && !wrCcA |=> $stable(ccA_q))
      else $error("edge b captured while pin drives");
endmodule
`default_nettype wire

// ==== tb/tcc_edge_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_partner
(
   // block pins
   input  wire logic pinOut,
   input  wire logic pinOe_n,
   // edge inputs toward the block
   output logic      edgeA,
   output logic      pinIn
);
   logic levelB;

   initial
   begin
      edgeA  = 1'b0;
      levelB = 1'b0;
   end

   // the block owns the pin while its enable is low; the far side only drives otherwise
   assign pinIn = pinOe_n ? levelB : pinOut;

   // called right after a clock edge; the caller keeps each level for over two count clocks
   task automatic setLevels(input logic a, input logic b);
      edgeA  <= a;
      levelB <= b;
   endtask
endmodule
`default_nettype wire

// ==== tb/tcc_timer16_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_tb;
   import tcc_pkg::*;

   typedef struct packed
   {
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } tcc_row_s;

   logic        clk;
   logic        reset;
   logic        regWrite;
   logic        regRead;
   logic [2:0]  regAddr;
   logic [15:0] regWrData;
   logic [15:0] regRdData;
   logic        edgeA;
   logic        pinIn;
   logic        pinOut;
   logic        pinOe_n;
   logic        irqA;
   logic        irqB;
   logic        ovf;
   logic [15:0] v;
   logic [15:0] w;
   logic [15:0] t;
   int          errCount;
   int          nTests;
   int          cyc;
   int          wd;
   tcc_row_s    rows [5] = '{'{ADDR_CCA, 16'h1234, 16'h1234}, '{ADDR_CCB, 16'habcd, 16'habcd},
                             '{ADDR_CCA, 16'hffff, 16'hffff}, '{ADDR_COUNT, 16'h5555, 16'h0000},
                             '{3'h7, 16'h1234, 16'h0000}};

   tcc_timer16 i_dut
   (
      .clk          (clk),
      .reset        (reset),
      .regAddr      (regAddr),
      .regWrData    (regWrData),
      .regWrite     (regWrite),
      .regRead      (regRead),
      .regRdData    (regRdData),
      .edgeInputA   (edgeA),
      .sharedPinIn  (pinIn),
      .sharedPinOut (pinOut),
      .sharedPinOe_n(pinOe_n),
      .matchIrqA    (irqA),
      .matchIrqB    (irqB),
      .overflowFlag (ovf)
   );

   tcc_edge_partner i_part
   (
      .pinOut (pinOut),
      .pinOe_n(pinOe_n),
      .edgeA  (edgeA),
      .pinIn  (pinIn)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // the overflow wait alone takes 65536 cycles, everything else a few hundred
   always @(posedge clk)
   begin
      wd++;
      if (wd == 75000)
      begin
         errCount++;
         endOfTest();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errCount++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic waitIrq(input bit useB, input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (((useB ? irqB : irqA) !== 1'b1) && n < lim);
   endtask

   // control registers are only rewritten with the timer stopped
   task automatic setup(input logic [15:0] ca, cb, ctl, presc, mode);
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_CCA, ca);
      wr(ADDR_CCB, cb);
      wr(ADDR_CCCTL, ctl);
      wr(ADDR_PRESC, presc);
      wr(ADDR_OUTCTL, 16'h0000);
      wr(ADDR_MODE, mode);
   endtask

   // count read in the cycle the pins change: that tick is dropped, so the capture sees d+1
   task automatic readWithEdges(input logic a, input logic b, output logic [15:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= ADDR_COUNT;
      i_part.setLevels(a, b);
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
      repeat (5) @(posedge clk);
   endtask

   task automatic endOfTest();
      $display("comparisons %0d, mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      reset     = 1'b1;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      regAddr   = 3'h0;
      regWrData = 16'h0000;
      errCount  = 0;
      nTests    = 0;
      wd        = 0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      #1 chk({11'h0, irqA, irqB, pinOut, pinOe_n, ovf}, 16'h0002);
      for (int i = 0; i < 7; i++)
      begin
         rd(i[2:0], v);
         chk(v, 16'h0000);
      end
      $display("done: reset values");

      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk(v, rows[i].exp);
      end
      $display("done: register rows");

      setup(16'h0100, 16'h0200, 16'h0000, 16'h0000, 16'h0004);
      repeat (8) @(posedge clk);
      regRead <= 1'b1;
      regAddr <= ADDR_COUNT;
      @(posedge clk);
      #1 v = regRdData;
      @(posedge clk);
      regRead <= 1'b0;
      #1 w = regRdData;
      chk(w, v);
      rd(ADDR_COUNT, w);
      chk(w, v + 16'h0001);
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_COUNT, v);
      chk(v, 16'h0000);
      // divide by four: ticks land on the 4th, 8th, ... running cycle
      setup(16'h0100, 16'h0200, 16'h0000, 16'h0001, 16'h0004);
      repeat (19) @(posedge clk);
      rd(ADDR_COUNT, v);
      chk(v, 16'h0005);
      $display("done: count and read hold");

      setup(16'h0005, 16'h0008, 16'h0000, 16'h0000, 16'h0004);
      waitIrq(1'b0, 50, cyc);
      waitIrq(1'b1, 10, cyc);
      chk(cyc[15:0], 16'h0003);
      chk({15'h0, pinOut}, 16'h0001);
      // nonzero compare values in match-clear mode
      setup(16'h0003, 16'h0002, 16'h0000, 16'h0000, 16'h000c);
      waitIrq(1'b0, 50, cyc);
      waitIrq(1'b0, 50, cyc);
      chk(cyc[15:0], 16'h0004);
      $display("done: compare");

      // edge a rising only, edge b both ways; code 10 is never programmed
      setup(16'h0000, 16'h0000, 16'h0005, 16'h00d0, 16'h0004);
      repeat (10) @(posedge clk);
      readWithEdges(1'b1, 1'b1, v);
      rd(ADDR_CCB, t);
      chk(t, v + 16'h0001);
      rd(ADDR_CCA, w);
      chk(w, v + 16'h0001);
      readWithEdges(1'b0, 1'b0, v);
      rd(ADDR_CCB, w);
      chk(w, t);
      rd(ADDR_CCA, t);
      chk(t, v + 16'h0001);
      wr(ADDR_OUTCTL, 16'h0001);
      rd(ADDR_CCA, t);
      chk({15'h0, pinOe_n}, 16'h0000);
      readWithEdges(1'b0, 1'b1, v);
      rd(ADDR_CCA, w);
      chk(w, t);
      // register a on input a reverse phase: code 00 captures rising only
      setup(16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0004);
      repeat (10) @(posedge clk);
      readWithEdges(1'b1, 1'b1, v);
      rd(ADDR_CCA, w);
      chk(w, v + 16'h0001);
      readWithEdges(1'b0, 1'b1, t);
      rd(ADDR_CCA, t);
      chk(t, w);
      $display("done: capture");

      setup(16'h1000, 16'h1000, 16'h0000, 16'h0010, 16'h0008);
      repeat (10) @(posedge clk);
      i_part.setLevels(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      regRead <= 1'b1;
      regAddr <= ADDR_COUNT;
      @(posedge clk);
      regRead <= 1'b0;
      #1 v = regRdData;
      chk(v, 16'h0000);
      wr(ADDR_OUTCTL, 16'h0060);
      rd(ADDR_COUNT, v);
      chk(v, 16'h0001);
      $display("done: clear conditions");

      setup(16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0004);
      waitIrq(1'b0, 70000, cyc);
      chk({15'h0, ovf}, 16'h0001);
      waitIrq(1'b1, 4, cyc);
      chk(cyc[15:0], 16'h0001);
      rd(ADDR_MODE, v);
      chk(v, 16'h0005);
      wr(ADDR_MODE, 16'h0004);
      rd(ADDR_MODE, v);
      chk(v, 16'h0004);
      $display("done: overflow");

      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_COUNT, v);
      chk(v, 16'h0000);
      rd(ADDR_CCA, v);
      chk(v, 16'h0000);
      $display("done: mid-run reset");
      endOfTest();
   end
endmodule
`default_nettype wire
